// >>> rtl/rmb_pkg.sv
package rmb_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned RESET_TAIL_OUTCLK = 2;    // output-clock periods after release
   localparam int unsigned STRAP_LATE_OUTCLK = 4;    // second strap sample
   localparam int unsigned FETCH_HALF_CYCLES = 13;   // six and a half output clocks
   localparam int unsigned MIN_CLEAR_OUTCLK  = 4;
   localparam int unsigned WAIT_RESAMPLE     = 5;    // output clocks between samples
   localparam int unsigned SYNC_STAGES       = 3;
   // Output clock = core clock / 2, so one output period is two core cycles
   localparam int unsigned CYC_PER_OUTCLK    = 2;
   localparam int unsigned RESET_TAIL_CYC    = RESET_TAIL_OUTCLK * CYC_PER_OUTCLK;
   localparam int unsigned STRAP_LATE_CYC    = STRAP_LATE_OUTCLK * CYC_PER_OUTCLK;
   localparam int unsigned FETCH_CYC         = FETCH_HALF_CYCLES;
   localparam int unsigned WAIT_CYC          = WAIT_RESAMPLE * CYC_PER_OUTCLK;
   localparam int unsigned CNT_W             = 5;

   // ------------------------------------------------------------
   // Bus fields
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W    = 20;
   localparam int unsigned DATA_W    = 16;
   localparam int unsigned UPPER_W   = 4;
   localparam int unsigned UPPER_LSB = 16;

   typedef enum logic [1:0] {
      RMB_RST_HOLD = 2'b00,
      RMB_RST_TAIL = 2'b01,
      RMB_RST_RUN  = 2'b10
   } rmb_rst_t;

   typedef enum logic [2:0] {
      RMB_BUS_IDLE = 3'b000,
      RMB_BUS_T1   = 3'b001,
      RMB_BUS_T2   = 3'b010,
      RMB_BUS_T3   = 3'b011,
      RMB_BUS_TW   = 3'b100,
      RMB_BUS_T4   = 3'b101
   } rmb_bus_t;
endpackage

// >>> rtl/rmb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rmb_sync
   import rmb_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] syncOut
);
   // Three stages; the output moves only when stages two and three agree
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r    <= '0;
         s2_r    <= '0;
         s3_r    <= '0;
         syncOut <= '0;
      end else begin
         s1_r <= pinIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < int'(WIDTH); i++) begin
            if (s2_r[i] == s3_r[i]) begin
               syncOut[i] <= s3_r[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/rmb_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// ------------------------------------------------------------
module rmb_pins
   import rmb_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                externalClearInput_n,
   input  wire logic                strapBusyPin,
   input  wire logic [1:0]          counterInputPins,
   input  wire logic [1:0]          transferRequestPins,
   input  wire logic                unmaskablePin,
   input  wire logic [3:0]          maskableRequestPins,
   input  wire logic [3:0]          maskEdgeMode,
   input  wire logic [1:0]          ackOutMode,
   input  wire logic [1:0]          ackPulse,
   input  wire logic [1:0]          counterOutNxt,
   input  wire logic                holdGranted,
   input  wire logic                waitInstr,
   input  wire logic                busReq,
   input  wire logic                busDma,
   input  wire logic                busLowByte,
   input  wire logic [ADDR_W-1:0]   busAddr,
   input  wire logic [DATA_W-1:0]   busWrData,
   input  wire logic                busWrite,
   input  wire logic                busReady,
   input  wire logic                unmaskableTaken,
   output logic                     resetOut,
   output logic                     systemClockOutput,
   output logic                     enhancedMode,
   output logic                     fetchStart,
   output logic                     waitStall,
   output logic                     coprocBusy,
   output logic [1:0]               counterLevel,
   output logic [1:0]               counterTick,
   output logic [1:0]               counterOutputPins,
   output logic [1:0]               transferRequest,
   output logic                     unmaskableRequest,
   output logic [3:0]               maskableRequest,
   output logic [1:0]               acknowledgeOutputLow_n,
   output logic [1:0]               acknowledgeOutputOe,
   output logic [UPPER_W-1:0]       upperAddressStatusPins,
   output logic                     upperOe,
   output logic [DATA_W-1:0]        muxedAddrDataOut,
   output logic                     muxedOe,
   output logic [DATA_W-1:0]        busRdData,
   output logic                     busDone
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int unsigned NSYNC = 13;
   logic [NSYNC-1:0] syncIn;
   logic [NSYNC-1:0] syncOut;
   logic             clearSync_n;
   logic             strapSync;
   logic [1:0]       tinSync;
   logic [1:0]       drqSync;
   logic             nmiSync;
   logic [3:0]       intSync;
   logic             dummySync;

   // Strap pin is only ever read: the pull-up sits outside this block
   assign syncIn = {1'b0, externalClearInput_n, strapBusyPin, counterInputPins,
                    transferRequestPins, unmaskablePin, maskableRequestPins, 1'b0};
   rmb_sync #(.WIDTH(NSYNC)) uSync (
      .clk     (clk),
      .arst_n  (arst_n),
      .pinIn   (syncIn),
      .syncOut (syncOut)
   );
   assign {dummySync, clearSync_n, strapSync, tinSync, drqSync, nmiSync, intSync} =
      syncOut[NSYNC-1:1];

   // ------------------------------------------------------------
   // Clock divider
   // ------------------------------------------------------------
   // Free running: not gated by clear or hold
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         systemClockOutput <= 1'b0;
      end else begin
         systemClockOutput <= ~systemClockOutput;
      end
   end

   // ------------------------------------------------------------
   // Reset sequencing
   // ------------------------------------------------------------
   rmb_rst_t         rstSt_r;
   logic [CNT_W-1:0] rstCnt_r;
   logic             clearPrev_r;
   logic             strapAtRise_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSt_r       <= RMB_RST_HOLD;
         rstCnt_r      <= '0;
         resetOut      <= 1'b1;
         fetchStart    <= 1'b0;
         enhancedMode  <= 1'b0;
         clearPrev_r   <= 1'b0;
         strapAtRise_r <= 1'b0;
      end else begin
         clearPrev_r <= clearSync_n;
         fetchStart  <= 1'b0;
         if (!clearSync_n) begin
            rstSt_r  <= RMB_RST_HOLD;
            rstCnt_r <= '0;
            resetOut <= 1'b1;
         end else begin
            case (rstSt_r)
               RMB_RST_HOLD: begin
                  rstSt_r       <= RMB_RST_TAIL;
                  rstCnt_r      <= CNT_W'(1);
                  strapAtRise_r <= strapSync;
               end
               RMB_RST_TAIL: begin
                  rstCnt_r <= rstCnt_r + CNT_W'(1);
                  if (rstCnt_r == CNT_W'(RESET_TAIL_CYC - 1)) begin
                     resetOut <= 1'b0;
                  end
                  // Second sample a full eight core cycles after the first one
                  if (rstCnt_r == CNT_W'(STRAP_LATE_CYC)) begin
                     enhancedMode <= strapAtRise_r & ~strapSync;
                  end
                  if (rstCnt_r == CNT_W'(FETCH_CYC - 1)) begin
                     fetchStart <= 1'b1;
                     rstSt_r    <= RMB_RST_RUN;
                  end
               end
               RMB_RST_RUN: begin
                  rstCnt_r <= rstCnt_r;
               end
               default: begin
                  rstSt_r <= RMB_RST_HOLD;
               end
            endcase
         end
      end
   end

   logic running;
   assign running = (rstSt_r == RMB_RST_RUN);

   // ------------------------------------------------------------
   // Strap pin as wait test or coprocessor busy
   // ------------------------------------------------------------
   logic [CNT_W-1:0] waitCnt_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         waitStall  <= 1'b0;
         waitCnt_r  <= '0;
         coprocBusy <= 1'b0;
      end else begin
         coprocBusy <= enhancedMode & strapSync & running;
         if (!running || enhancedMode) begin
            waitStall <= 1'b0;
            waitCnt_r <= '0;
         end else if (waitInstr && !waitStall) begin
            waitStall <= strapSync;
            waitCnt_r <= '0;
         end else if (waitStall) begin
            if (waitCnt_r == CNT_W'(WAIT_CYC - 1)) begin
               waitCnt_r <= '0;
               waitStall <= strapSync;
            end else begin
               waitCnt_r <= waitCnt_r + CNT_W'(1);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Counter, transfer and interrupt inputs
   // ------------------------------------------------------------
   logic [1:0] tinPrev_r;
   logic       nmiPrev_r;
   logic [3:0] intPrev_r;
   logic [3:0] intAckMask;
   assign intAckMask = {ackOutMode, 2'b00};
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tinPrev_r         <= '0;
         counterLevel      <= '0;
         counterTick       <= '0;
         transferRequest   <= '0;
         nmiPrev_r         <= 1'b0;
         unmaskableRequest <= 1'b0;
         intPrev_r         <= '0;
         maskableRequest   <= '0;
      end else begin
         tinPrev_r       <= tinSync;
         counterLevel    <= tinSync;
         counterTick     <= tinSync & ~tinPrev_r;
         transferRequest <= drqSync & {2{running}};
         nmiPrev_r       <= nmiSync;
         intPrev_r       <= intSync;
         if (!running) begin
            unmaskableRequest <= 1'b0;
         end else if (nmiSync && !nmiPrev_r) begin
            unmaskableRequest <= 1'b1;
         end else if (unmaskableTaken) begin
            unmaskableRequest <= 1'b0;
         end
         for (int i = 0; i < 4; i++) begin
            if (intAckMask[i]) begin
               maskableRequest[i] <= 1'b0;
            end else if (maskEdgeMode[i]) begin
               maskableRequest[i] <= intSync[i] & ~intPrev_r[i];
            end else begin
               maskableRequest[i] <= intSync[i];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         counterOutputPins      <= '0;
         acknowledgeOutputLow_n <= 2'b11;
         acknowledgeOutputOe    <= '0;
      end else begin
         counterOutputPins      <= running ? counterOutNxt : 2'b00;
         acknowledgeOutputLow_n <= ~(ackPulse & ackOutMode);
         acknowledgeOutputOe    <= ackOutMode;
      end
   end

   // ------------------------------------------------------------
   // Multiplexed bus sequencer
   // ------------------------------------------------------------
   rmb_bus_t          busSt_r;
   logic [ADDR_W-1:0] addr_r;
   logic              dma_r;
   logic              low_r;
   logic              wr_r;
   logic [DATA_W-1:0] wdat_r;
   logic              drive;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busSt_r <= RMB_BUS_IDLE;
         addr_r  <= '0;
         dma_r   <= 1'b0;
         low_r   <= 1'b0;
         wr_r    <= 1'b0;
         wdat_r  <= '0;
         busDone <= 1'b0;
      end else begin
         busDone <= 1'b0;
         if (!running || holdGranted) begin
            busSt_r <= RMB_BUS_IDLE;
         end else begin
            case (busSt_r)
               RMB_BUS_IDLE: begin
                  if (busReq) begin
                     busSt_r <= RMB_BUS_T1;
                     addr_r  <= busAddr;
                     dma_r   <= busDma;
                     low_r   <= busLowByte;
                     wr_r    <= busWrite;
                     wdat_r  <= busWrData;
                  end
               end
               RMB_BUS_T1: busSt_r <= RMB_BUS_T2;
               RMB_BUS_T2: busSt_r <= RMB_BUS_T3;
               RMB_BUS_T3: busSt_r <= busReady ? RMB_BUS_T4 : RMB_BUS_TW;
               RMB_BUS_TW: busSt_r <= busReady ? RMB_BUS_T4 : RMB_BUS_TW;
               RMB_BUS_T4: begin
                  busSt_r <= RMB_BUS_IDLE;
                  busDone <= 1'b1;
               end
               default: busSt_r <= RMB_BUS_IDLE;
            endcase
         end
      end
   end

   // Clear floats the bus one edge before the sequencer returns to idle
   assign drive = running && !holdGranted && clearSync_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         upperAddressStatusPins <= '0;
         upperOe                <= 1'b0;
         muxedAddrDataOut       <= '0;
         muxedOe                <= 1'b0;
         busRdData              <= '0;
      end else begin
         upperOe <= drive;
         muxedOe <= drive && (busSt_r == RMB_BUS_T1 || wr_r && busSt_r != RMB_BUS_IDLE);
         if (busSt_r == RMB_BUS_T1) begin
            upperAddressStatusPins <= addr_r[UPPER_LSB +: UPPER_W];
            muxedAddrDataOut <= {addr_r[DATA_W-1:1], addr_r[0] & ~low_r};
         end else begin
            upperAddressStatusPins <= {dma_r, 3'b000};
            muxedAddrDataOut       <= wdat_r;
         end
         if (busSt_r == RMB_BUS_T3 && busReady) begin
            busRdData <= muxedAddrDataOut;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_reset_tail: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(clearSync_n) |-> resetOut [*4] ##1 !resetOut)
      else $error("reset output tail length wrong");
   a_clock_toggles: assert property (@(posedge clk) disable iff (!arst_n)
      $past(arst_n) |-> systemClockOutput != $past(systemClockOutput))
      else $error("system clock output stalled");
   a_clear_aborts: assert property (@(posedge clk) disable iff (!arst_n)
      !clearSync_n |=> resetOut && !upperOe && !muxedOe)
      else $error("clear did not abort activity");
   a_fetch_time: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(clearSync_n) |-> ##13 fetchStart)
      else $error("fetch start at wrong time");
   a_float_hold: assert property (@(posedge clk) disable iff (!arst_n)
      holdGranted |=> !upperOe && !muxedOe)
      else $error("bus driven during hold");
   a_nmi_latch: assert property (@(posedge clk) disable iff (!arst_n)
      running && $rose(nmiSync) |=> unmaskableRequest)
      else $error("unmaskable edge lost");
   a_status_bits: assert property (@(posedge clk) disable iff (!arst_n)
      busSt_r == RMB_BUS_T2 |=> upperAddressStatusPins[2:0] == 3'b000)
      else $error("status bits not low");
   a_wait_stall: assert property (@(posedge clk) disable iff (!arst_n)
      enhancedMode |=> !waitStall)
      else $error("wait stall in enhanced mode");
endmodule
`default_nettype wire

// >>> dv/rmb_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Local bus memory model: latches what the pins show, answers ready
// ------------------------------------------------------------
module rmb_far_side
   import rmb_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic [UPPER_W-1:0] upperAddressStatusPins,
   input  wire logic               upperOe,
   input  wire logic [DATA_W-1:0]  muxedAddrDataOut,
   input  wire logic               muxedOe,
   input  wire logic               busDone,
   input  wire logic [3:0]         readyDelay,
   output logic                    busReady,
   output logic [ADDR_W-1:0]       capAddr,
   output logic [UPPER_W-1:0]      capStatus,
   output logic [DATA_W-1:0]       capData
);
   logic [3:0] phase_r;

   // Ready drops between cycles so a stale ready never ends the next one early
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_r   <= 4'h0;
         busReady  <= 1'b0;
         capAddr   <= 20'h0_0000;
         capStatus <= 4'h0;
         capData   <= 16'h0000;
      end else if (!upperOe || busDone) begin
         phase_r  <= 4'h0;
         busReady <= 1'b0;
      end else if (phase_r == 4'h0 && !muxedOe) begin
         // Idle bus: wait for the address phase before counting
         busReady <= 1'b0;
      end else begin
         if (phase_r != 4'hf) begin
            phase_r <= phase_r + 4'h1;
         end
         if (phase_r == 4'h0) begin
            capAddr <= {upperAddressStatusPins, muxedAddrDataOut};
         end
         if (phase_r == 4'h1) begin
            capStatus <= upperAddressStatusPins;
            capData   <= muxedOe ? muxedAddrDataOut : ~capData;
         end
         busReady <= (phase_r >= readyDelay);
      end
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import rmb_pkg::*;
();
   logic clk, arst_n, clearPin_n, strap, strapTie, unmaskablePin, holdGranted, waitInstr;
   logic busReq, busDma, busLowByte, busWrite, unmaskableTaken, busReady;
   logic [1:0] counterInputPins, transferRequestPins, ackOutMode, ackPulse, counterOutNxt;
   logic [3:0] maskableRequestPins, maskEdgeMode, readyDelay, capStatus;
   logic [19:0] busAddr, capAddr;
   logic [15:0] busWrData, capData;
   wire logic strapBusyPin;
   logic resetOut, systemClockOutput, enhancedMode, fetchStart, waitStall, coprocBusy;
   logic unmaskableRequest, upperOe, muxedOe, busDone;
   logic [1:0] counterLevel, counterTick, counterOutputPins, transferRequest;
   logic [1:0] acknowledgeOutputLow_n, acknowledgeOutputOe;
   logic [3:0] maskableRequest, upperAddressStatusPins;
   logic [15:0] muxedAddrDataOut, busRdData;
   int seed, fails, checks;

   // Strap may be tied to the reset output, as a board would do for enhanced mode
   assign strapBusyPin = strapTie ? resetOut : strap;

   rmb_pins dut_u (.clk(clk), .arst_n(arst_n), .externalClearInput_n(clearPin_n),
      .strapBusyPin(strapBusyPin), .counterInputPins(counterInputPins),
      .transferRequestPins(transferRequestPins), .unmaskablePin(unmaskablePin),
      .maskableRequestPins(maskableRequestPins), .maskEdgeMode(maskEdgeMode),
      .ackOutMode(ackOutMode), .ackPulse(ackPulse), .counterOutNxt(counterOutNxt),
      .holdGranted(holdGranted), .waitInstr(waitInstr), .busReq(busReq), .busDma(busDma),
      .busLowByte(busLowByte), .busAddr(busAddr), .busWrData(busWrData),
      .busWrite(busWrite), .busReady(busReady), .unmaskableTaken(unmaskableTaken),
      .resetOut(resetOut), .systemClockOutput(systemClockOutput),
      .enhancedMode(enhancedMode), .fetchStart(fetchStart), .waitStall(waitStall),
      .coprocBusy(coprocBusy), .counterLevel(counterLevel), .counterTick(counterTick),
      .counterOutputPins(counterOutputPins), .transferRequest(transferRequest),
      .unmaskableRequest(unmaskableRequest), .maskableRequest(maskableRequest),
      .acknowledgeOutputLow_n(acknowledgeOutputLow_n),
      .acknowledgeOutputOe(acknowledgeOutputOe),
      .upperAddressStatusPins(upperAddressStatusPins), .upperOe(upperOe),
      .muxedAddrDataOut(muxedAddrDataOut), .muxedOe(muxedOe), .busRdData(busRdData),
      .busDone(busDone));

   rmb_far_side far_u (.clk(clk), .arst_n(arst_n),
      .upperAddressStatusPins(upperAddressStatusPins), .upperOe(upperOe),
      .muxedAddrDataOut(muxedAddrDataOut), .muxedOe(muxedOe), .busDone(busDone),
      .readyDelay(readyDelay), .busReady(busReady), .capAddr(capAddr),
      .capStatus(capStatus), .capData(capData));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic timeout(input string what);
      fails++;
      $display("wrong value %s expected done seen timeout", what);
      report_and_stop();
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   function automatic logic [19:0] exp_addr(input logic [19:0] a, input logic lb);
      return {a[19:1], a[0] & ~lb};
   endfunction

   function automatic logic exp_mode(input logic a, input logic b, input logic tie);
      return tie | (a & ~b);
   endfunction

   task automatic clk_toggles;
      logic prev, want;
      prev = systemClockOutput;
      repeat (4) begin
         tick(1);
         want = ~prev;
         chk("clock out", systemClockOutput, want);
         prev = systemClockOutput;
      end
   endtask

   task automatic restart(input logic a, input logic b, input logic tie);
      int n, m;
      clearPin_n = 1'b0;
      strap = a;
      strapTie = tie;
      tick(6);
      chk("reset in clear", resetOut, 1);
      chk("upper oe in reset", upperOe, 0);
      chk("muxed oe in reset", muxedOe, 0);
      clk_toggles();
      clearPin_n = 1'b1;
      n = 0;
      while (resetOut === 1'b1 && n < 20) begin
         tick(1);
         n++;
         if (n == 5) begin
            strap = b;
         end
      end
      chk("reset tail", (n == 7 || n == 8), 1);
      m = 0;
      while (fetchStart !== 1'b1 && m < 20) begin
         tick(1);
         m++;
      end
      chk("fetch delay", m, 9);
      chk("mode", enhancedMode, exp_mode(a, b, tie));
      strapTie = 1'b0;
   endtask

   task automatic bus_start(input logic [19:0] a, input logic [2:0] flags, input logic [3:0] d);
      busAddr = a;
      busDma = flags[2];
      busLowByte = flags[1];
      busWrite = flags[0];
      busWrData = 16'($random(seed));
      readyDelay = d;
      busReq = 1'b1;
      tick(1);
      busReq = 1'b0;
   endtask

   task automatic bus_cycle(input logic [19:0] a, input logic [2:0] flags, input logic [3:0] d);
      int n;
      bus_start(a, flags, d);
      n = 0;
      while (busDone !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      if (n >= 40) begin
         timeout("bus done");
      end
      chk("done latency", n >= 4, 1);
      chk("t1 address", capAddr, exp_addr(a, flags[1]));
      chk("status bits", capStatus, {flags[2], 3'b000});
      if (flags[0]) begin
         chk("write data", capData, busWrData);
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] v;
      logic [1:0] ackSeen, ackWant;
      int n, pm, pt;
      {arst_n, clearPin_n, strap, strapTie, unmaskablePin, holdGranted, waitInstr} = '0;
      {busReq, busDma, busLowByte, busWrite, unmaskableTaken, readyDelay} = '0;
      {counterInputPins, transferRequestPins, ackOutMode, ackPulse, counterOutNxt} = '0;
      {maskableRequestPins, maskEdgeMode, busAddr, busWrData} = '0;
      seed = 69087;
      fails = 0;
      checks = 0;
      tick(6);
      arst_n = 1'b1;
      restart(1'b1, 1'b0, 1'b0);
      restart(1'b1, 1'b1, 1'b1);
      strap = 1'b1;
      tick(5);
      chk("busy high", coprocBusy, 1);
      strap = 1'b0;
      tick(5);
      chk("busy low", coprocBusy, 0);
      restart(1'b1, 1'b1, 1'b0);
      restart(1'b0, 1'b1, 1'b0);
      restart(1'b0, 1'b0, 1'b0);
      strap = 1'b1;
      tick(5);
      waitInstr = 1'b1;
      tick(1);
      waitInstr = 1'b0;
      tick(12);
      chk("stall held", waitStall, 1);
      strap = 1'b0;
      n = 0;
      while (waitStall === 1'b1 && n < 30) begin
         tick(1);
         n++;
      end
      chk("stall release", n <= 16, 1);
      bus_cycle(20'hF_FFFF, 3'b111, 4'h0);
      bus_cycle(20'h0_0001, 3'b000, 4'h7);
      repeat (24) begin
         v = $random(seed);
         bus_cycle(v[19:0], v[22:20], {1'b0, v[25:23]});
      end
      bus_start(20'hA_5A5A, 3'b001, 4'h7);
      tick(2);
      holdGranted = 1'b1;
      counterOutNxt = 2'b10;
      tick(3);
      chk("upper float", upperOe, 0);
      chk("muxed float", muxedOe, 0);
      chk("reset kept", resetOut, 0);
      chk("counter out", counterOutputPins, 2'b10);
      clk_toggles();
      holdGranted = 1'b0;
      tick(4);
      bus_cycle(20'h1_2345, 3'b001, 4'h2);
      // Clear in mid-cycle must abort the transfer and float the bus
      bus_start(20'h5_4321, 3'b100, 4'h5);
      tick(2);
      restart(1'b0, 1'b0, 1'b0);
      repeat (20) begin
         v = $random(seed);
         transferRequestPins = v[1:0];
         counterInputPins = v[3:2];
         maskableRequestPins = v[7:4];
         ackOutMode = v[9:8];
         ackPulse = v[11:10];
         counterOutNxt = v[13:12];
         tick(6);
         ackSeen = acknowledgeOutputLow_n | ~v[9:8];
         ackWant = ~(v[11:10] & v[9:8]);
         chk("transfer request", transferRequest, v[1:0]);
         chk("counter level", counterLevel, v[3:2]);
         chk("maskable level", maskableRequest[1:0], v[5:4]);
         chk("ack enable", acknowledgeOutputOe, v[9:8]);
         chk("ack level", ackSeen, ackWant);
         chk("counter out", counterOutputPins, v[13:12]);
      end
      maskEdgeMode = 4'b0001;
      maskableRequestPins = 4'b0000;
      counterInputPins = 2'b00;
      tick(6);
      maskableRequestPins = 4'b0001;
      counterInputPins = 2'b01;
      unmaskablePin = 1'b1;
      tick(2);
      unmaskablePin = 1'b0;
      pm = 0;
      pt = 0;
      repeat (8) begin
         tick(1);
         pm += int'(maskableRequest[0] === 1'b1);
         pt += int'(counterTick[0] === 1'b1);
      end
      chk("edge request pulses", pm, 1);
      chk("counter ticks", pt, 1);
      chk("unmaskable latched", unmaskableRequest, 1);
      unmaskableTaken = 1'b1;
      tick(1);
      unmaskableTaken = 1'b0;
      tick(2);
      chk("unmaskable cleared", unmaskableRequest, 0);
      report_and_stop();
   end
endmodule
`default_nettype wire
